// [testbench/spcl_motor_model.sv]
// motor and power stage model seen by the stall block
`timescale 1ns/1ps
module spcl_motor_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [15:0] load,
   input wire logic [15:0] freq_set,
   input wire logic [1:0] req_motion,
   input wire spcl_pkg::spcl_freq_cmd_type freq_cmd,
   input wire logic output_shutoff,
   output logic [15:0] current_inverter,
   output logic [15:0] current_pm,
   output logic [15:0] output_freq,
   output spcl_pkg::spcl_motion_type motion
);
   // shut off stage carries no current; pm reading offset so both paths differ
   assign current_inverter = output_shutoff ? 16'h0000 : load;
   assign current_pm = output_shutoff ? 16'h0000 : load + 16'h0064;
   assign motion = spcl_pkg::spcl_motion_type'(req_motion);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_freq <= 16'h0000;
      end else if (freq_cmd.decelerate && output_freq != 16'h0000) begin
         output_freq <= output_freq - 16'h0001;
      end else if (!freq_cmd.hold) begin
         output_freq <= freq_set;
      end
   end
endmodule : spcl_motor_model

// [testbench/spcl_stall_ctrl_assertions.sv]
// port assertions of the stall prevention block
`timescale 1ns/1ps
module spcl_checker #(
   parameter int MIN_ON_CYCLES = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic [15:0] current_inverter,
   input wire logic [15:0] current_pm,
   input wire spcl_pkg::spcl_motion_type motion,
   input wire logic running,
   input wire spcl_pkg::spcl_freq_cmd_type freq_cmd,
   input wire logic output_shutoff,
   input wire logic stall_indication_output
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // length of the present indication pulse
   int on_cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_cnt <= 0;
      end else begin
         on_cnt <= stall_indication_output ? on_cnt + 1 : 0;
      end
   end
   property p_hold_decel;
      freq_cmd.hold |-> $past(motion) == spcl_pkg::SPCL_DECEL;
   endproperty
   a_hold_decel: assert property (p_hold_decel) else $error("hold outside deceleration");
   property p_dec_cmd;
      freq_cmd.decelerate |-> $past(motion) inside {spcl_pkg::SPCL_ACCEL, spcl_pkg::SPCL_CONST};
   endproperty
   a_dec_cmd: assert property (p_dec_cmd) else $error("decelerate while decelerating");
   property p_idle;
      !running |=> freq_cmd == 2'b00;
   endproperty
   a_idle: assert property (p_idle) else $error("frequency command while stopped");
   property p_shut;
      output_shutoff |-> $past(current_inverter > spcl_pkg::FAST_LIMIT_DEF || current_pm > spcl_pkg::FAST_LIMIT_DEF);
   endproperty
   a_shut: assert property (p_shut) else $error("shutoff without overcurrent");
   property p_min_on;
      $fell(stall_indication_output) |-> $past(on_cnt) >= MIN_ON_CYCLES;
   endproperty
   a_min_on: assert property (p_min_on) else $error("indication pulse too short");
   property p_ind_cause;
      $rose(stall_indication_output) |-> $past(freq_cmd) != 2'b00;
   endproperty
   a_ind_cause: assert property (p_ind_cause) else $error("indication without stall");
   property p_ready;
      psel && !penable |=> pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready) else $error("pready not a single access cycle");
   property p_rdata;
      !(pready && !pwrite) |-> prdata == 32'h0000_0000;
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data outside read access");
endmodule : spcl_checker
bind spcl_stall_ctrl spcl_checker #(.MIN_ON_CYCLES(MIN_ON_CYCLES)) spcl_checker_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
   .current_inverter(current_inverter), .current_pm(current_pm), .motion(motion), .running(running),
   .freq_cmd(freq_cmd), .output_shutoff(output_shutoff), .stall_indication_output(stall_indication_output));

// [testbench/test_spcl_stall_ctrl.sv]
// self-checking bench of the stall prevention block
`timescale 1ns/1ps
module test_spcl_stall_ctrl;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [15:0] cur_inv, cur_pm, ofreq, load = 16'h0, fset = 16'h0;
   logic [1:0] req = 2'b00;
   logic running = 1'b0, sel = 1'b0, vred, shut, ind;
   logic [9:0] ain = 10'h000;
   spcl_pkg::spcl_motion_type motion;
   spcl_pkg::spcl_freq_cmd_type fc;
   int fails = 0, num_checks = 0;
   always #2.5 pclk = ~pclk;
   spcl_stall_ctrl #(.STEP_CYCLES(8), .MIN_ON_CYCLES(20)) spcl_stall_ctrl_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .current_inverter(cur_inv), .current_pm(cur_pm), .output_freq(ofreq),
      .motion(motion), .running(running), .second_set_select(sel), .analog_level_input(ain), .freq_cmd(fc),
      .voltage_reduce(vred), .output_shutoff(shut), .stall_indication_output(ind));
   spcl_motor_model spcl_motor_model_i (.pclk(pclk), .presetn(presetn), .load(load), .freq_set(fset),
      .req_motion(req), .freq_cmd(fc), .output_shutoff(shut), .current_inverter(cur_inv), .current_pm(cur_pm),
      .output_freq(ofreq), .motion(motion));
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ee, output logic [31:0] r);
      int k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      r = prdata;
      chk("response", {pready, pslverr}, {1'b1, ee});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
      logic [31:0] r;
      apb(1'b1, a, d, ee, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, a > 8'h20, r);
      chk("read", r & m, e);
   endtask : rd
   task automatic settle();
      repeat (4) @(posedge pclk);
      #1;
   endtask : settle
   task automatic drive(input logic [15:0] l, input logic [1:0] m, input logic [15:0] f);
      @(posedge pclk);
      running <= 1'b1;
      load <= l;
      req <= m;
      fset <= f;
      settle();
   endtask : drive
   task automatic stop();
      @(posedge pclk);
      running <= 1'b0;
      load <= 16'h0000;
      repeat (2) @(posedge pclk);
   endtask : stop
   task automatic wait_for(input string n, ref logic s, input logic v);
      int k = 0;
      while (s !== v && k < 60) begin
         @(posedge pclk);
         #1;
         k++;
      end
      chk(n, s, v);
   endtask : wait_for
   task automatic t_reset();
      rd(8'h00, 32'hffff, 32'h04b0);
      rd(8'h04, 32'hffff, 32'h270f);
      rd(8'h08, 32'hffff, 32'h04b0);
      rd(8'h0c, 32'h8000_ffff, 32'h0);
      rd(8'h10, 32'hffff, 32'h1770);
      rd(8'h14, 32'hffff_ffff, 32'h05dc_04b0);
      rd(8'h18, 32'h03ff_ff03, 32'h1);
      rd(8'h1c, 32'hffff, 32'h0);
      rd(8'h24, 32'hffff_ffff, 32'h0);
      wr(8'h20, 32'h1, 1'b1);
   endtask : t_reset
   task automatic t_range();
      wr(8'h00, 32'h05dd, 1'b1);
      rd(8'h00, 32'hffff, 32'h04b0);
      wr(8'h00, 32'h05dc, 1'b0);
      wr(8'h00, 32'h04b0, 1'b0);
      wr(8'h04, 32'h07d1, 1'b1);
      wr(8'h08, 32'h05dd, 1'b1);
      wr(8'h0c, 32'h9c41, 1'b1);
      wr(8'h10, 32'h9c41, 1'b1);
      wr(8'h14, 32'h05dd_04b0, 1'b1);
      wr(8'h1c, 32'h00fb, 1'b1);
      wr(8'h18, 32'h2001, 1'b1);
      wr(8'h18, 32'h6501, 1'b0);
      wr(8'h18, 32'h1f01, 1'b0);
      wr(8'h18, 32'h0001, 1'b0);
   endtask : t_range
   task automatic t_motion();
      logic [1:0] mv [3];
      logic [1:0] ev [3];
      mv = '{2'b01, 2'b00, 2'b10};
      ev = '{2'b10, 2'b10, 2'b01};
      for (int i = 0; i < 3; i++) begin
         drive(16'h04b1, mv[i], 16'h03e8);
         chk("freq_cmd", fc, ev[i]);
      end
      chk("indication", ind, 1'b1);
      rd(8'h20, 32'hffff_0001, 32'h04b0_0001);
      drive(16'h04b0, 2'b00, 16'h03e8);
      chk("freq_cmd", fc, 2'b00);
      for (int i = 0; i < 3; i++) begin
         wr(8'h18, 32'h0001 | (32'h0200 << i), 1'b0);
         drive(16'h04b1, mv[i], 16'h03e8);
         chk("freq_cmd", fc, 2'b00);
      end
      wr(8'h18, 32'h6501, 1'b0);
      drive(16'h06a5, 2'b00, 16'h03e8);
      chk("shutoff", shut, 1'b0);
      wr(8'h18, 32'h6400, 1'b0);
      wait_for("shutoff", shut, 1'b1);
      drive(16'h04b1, 2'b00, 16'h03e8);
      chk("voltage_reduce", vred, 1'b1);
      wr(8'h18, 32'h0001, 1'b0);
      settle();
      chk("voltage_reduce", vred, 1'b0);
   endtask : t_motion
   task automatic t_ind();
      stop();
      wr(8'h1c, 32'h0002, 1'b0);
      wait_for("indication", ind, 1'b0);
      drive(16'h04b1, 2'b00, 16'h03e8);
      chk("indication", ind, 1'b0);
      wait_for("indication", ind, 1'b1);
      drive(16'h03e8, 2'b00, 16'h03e8);
      chk("indication", ind, 1'b1);
      wait_for("indication", ind, 1'b0);
      stop();
      wr(8'h1c, 32'h270f, 1'b0);
      drive(16'h04b1, 2'b00, 16'h03e8);
      repeat (9) settle();
      chk("indication", ind, 1'b0);
      stop();
      wr(8'h1c, 32'h0, 1'b0);
   endtask : t_ind
   task automatic t_second();
      wr(8'h08, 32'h0320, 1'b0);
      wr(8'h0c, 32'h0bb8, 1'b0);
      drive(16'h0384, 2'b00, 16'h07d0);
      chk("freq_cmd", fc, 2'b10);
      rd(8'h20, 32'hffff_0008, 32'h0320_0008);
      drive(16'h0384, 2'b01, 16'h07d0);
      chk("freq_cmd", fc, 2'b00);
      drive(16'h0384, 2'b00, 16'h0fa0);
      chk("freq_cmd", fc, 2'b00);
      stop();
      wr(8'h0c, 32'h8000_0000, 1'b0);
      drive(16'h0384, 2'b00, 16'h07d0);
      chk("freq_cmd", fc, 2'b00);
      @(posedge pclk) sel <= 1'b1;
      drive(16'h0384, 2'b00, 16'h07d0);
      chk("freq_cmd", fc, 2'b10);
      stop();
      wr(8'h08, 32'h0578, 1'b0);
      drive(16'h0514, 2'b00, 16'h07d0);
      rd(8'h20, 32'hffff_0001, 32'h04b0_0001);
      stop();
      sel <= 1'b0;
      wr(8'h0c, 32'h0, 1'b0);
   endtask : t_second
   task automatic t_levels();
      wr(8'h18, 32'h0003, 1'b0);
      drive(16'h047e, 2'b00, 16'h03e8);
      chk("freq_cmd", fc, 2'b10);
      wr(8'h18, 32'h0001, 1'b0);
      settle();
      chk("freq_cmd", fc, 2'b00);
      stop();
      wr(8'h04, 32'h01f4, 1'b0);
      drive(16'h02bc, 2'b00, 16'h1b58);
      rd(8'h20, 32'hffff_0001, 32'h0258_0001);
      stop();
      drive(16'h02bc, 2'b00, 16'h1388);
      chk("freq_cmd", fc, 2'b00);
      stop();
      wr(8'h04, 32'h270f, 1'b0);
      ain <= 10'h200;
      wr(8'h00, 32'h270f, 1'b0);
      drive(16'h0547, 2'b00, 16'h03e8);
      rd(8'h20, 32'hffff_0001, 32'h0546_0001);
      wr(8'h00, 32'h04b0, 1'b0);
   endtask : t_levels
   task automatic t_access();
      stop();
      wr(8'h18, 32'h0001_0001, 1'b0);
      wr(8'h00, 32'h044c, 1'b1);
      wr(8'h18, 32'h0100_0001, 1'b0);
      drive(16'h0000, 2'b00, 16'h03e8);
      wr(8'h00, 32'h044c, 1'b0);
      rd(8'h00, 32'hffff, 32'h044c);
      wr(8'h18, 32'h0001, 1'b0);
      wr(8'h1c, 32'h0005, 1'b1);
      wr(8'h18, 32'h1001, 1'b0);
      drive(16'h04b1, 2'b00, 16'h03e8);
      chk("indication", ind, 1'b0);
   endtask : t_access
   task automatic final_report();
      if (fails == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      final_report();
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_range();
      t_motion();
      t_ind();
      t_second();
      t_levels();
      t_access();
      final_report();
   end
endmodule : test_spcl_stall_ctrl

// [verilog/spcl_pkg.sv]
// constants, register map and carrier types of the stall prevention block
package spcl_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_LEVEL = 8'h00;
   localparam logic [7:0] ADDR_FACTOR = 8'h04;
   localparam logic [7:0] ADDR_SECOND_LEVEL = 8'h08;
   localparam logic [7:0] ADDR_SECOND_FREQ = 8'h0c;
   localparam logic [7:0] ADDR_START_FREQ = 8'h10;
   localparam logic [7:0] ADDR_ANALOG = 8'h14;
   localparam logic [7:0] ADDR_CONTROL = 8'h18;
   localparam logic [7:0] ADDR_DELAY = 8'h1c;
   localparam logic [7:0] ADDR_STATUS = 8'h20;

   // percent values in 0.1 % steps, frequencies in 0.01 Hz steps, delay in 0.1 s steps
   localparam logic [15:0] SENTINEL = 16'h270f;
   localparam logic [15:0] PCT_MAX = 16'h05dc;
   localparam logic [15:0] FACTOR_MAX = 16'h07d0;
   localparam logic [15:0] FREQ_MAX = 16'h9c40;
   localparam logic [15:0] DELAY_MAX = 16'h00fa;
   localparam logic [31:0] FACTOR_UNIT = 32'h0000_03e8;

   // reset values and operation select codes
   localparam logic [15:0] LEVEL_DEF = 16'h04b0;
   localparam logic [15:0] SECOND_LEVEL_DEF = 16'h04b0;
   localparam logic [15:0] START_FREQ_DEF = 16'h1770;
   localparam logic [15:0] ANALOG_ZERO_DEF = 16'h04b0;
   localparam logic [15:0] ANALOG_FULL_DEF = 16'h05dc;
   localparam logic [7:0] OPSEL_ALL_ON = 8'h64;
   localparam logic [7:0] OPSEL_NO_FAST = 8'h65;
   localparam logic [7:0] OPSEL_TABLE_MAX = 8'h1f;

   // field positions
   localparam int CTRL_VRED_BIT = 0;
   localparam int CTRL_PM_BIT = 1;
   localparam int CTRL_OPSEL_LSB = 8;
   localparam int CTRL_UGRP_LSB = 16;
   localparam int CTRL_WPERM_LSB = 24;
   localparam int FREQ_FOLLOW_BIT = 31;
   localparam int ANALOG_FULL_LSB = 16;
   localparam int ANALOG_BITS = 10;
   localparam int OPSEL_FAST_OFF_BIT = 0;
   localparam int OPSEL_ACC_OFF_BIT = 1;
   localparam int OPSEL_CONST_OFF_BIT = 2;
   localparam int OPSEL_DEC_OFF_BIT = 3;
   localparam int OPSEL_IND_OFF_BIT = 4;

   // timing: one step of the indication timer and the least on time
   localparam int CLK_FREQ_HZ = 200_000_000;
   localparam int STEP_TIME_MS = 100;
   localparam int MIN_ON_TIME_MS = 100;
   localparam int STEP_CYCLES = STEP_TIME_MS * (CLK_FREQ_HZ / 1000);
   localparam int MIN_ON_CYCLES = MIN_ON_TIME_MS * (CLK_FREQ_HZ / 1000);

   // arbitrary fast-response limit, 170 %
   localparam logic [15:0] FAST_LIMIT_DEF = 16'h06a4;

   typedef enum logic [1:0] {
      SPCL_CONST = 2'b00,
      SPCL_ACCEL = 2'b01,
      SPCL_DECEL = 2'b10
   } spcl_motion_type;

   typedef enum logic [1:0] {
      IND_IDLE = 2'b00,
      IND_WAIT = 2'b01,
      IND_ON = 2'b11
   } spcl_ind_type;

   typedef struct packed {
      logic [15:0] level;
      logic [15:0] factor;
      logic [15:0] second_level;
      logic follow_select;
      logic [15:0] second_freq;
      logic [15:0] start_freq;
      logic [15:0] analog_zero;
      logic [15:0] analog_full;
      logic voltage_reduction;
      logic pm_motor;
      logic [7:0] opsel;
      logic [7:0] user_group;
      logic [1:0] write_perm;
      logic [15:0] delay;
   } spcl_settings_type;

   typedef struct packed {
      logic decelerate;
      logic hold;
   } spcl_freq_cmd_type;
endpackage : spcl_pkg

// [verilog/spcl_stall_ctrl.sv]
// stall prevention and fast-response current limit with apb settings
// How it works
// - current above active level alters output frequency to lower current
// - accel: decelerate; constant: decelerate; decel: suspend deceleration
// - indication output asserted while stall prevention acts, after delay setting
// - fast limit enabled and current above limit shuts inverter output off
// - level 0 disables, 0.1 to 150 % sets level, 9999 analog; default 120 %
// - level relative to inverter rated or magnet motor rated current
// - factor 0 to 200 % reduces level above reduction start frequency; 9999 keeps it
// - second level 0.1 to 150 %, default 120 %, 0 makes it invalid
// - second frequency 0 disables, 0.01 to 400 Hz sets upper frequency
// - second frequency 9999 uses second level only while select input on; here bit 31 of the register selects it and 9999 is 99.99 Hz
// - reduction start frequency 0 to 400 Hz, default 60 Hz
// - analog mode maps input between zero and full-scale levels, 0 to 150 %
// - voltage reduction select 0 reduces voltage while stalling, 1 does not
// - operation select 0 to 31, 100, 101 gates stall and fast limit
// - indication delay 0 to 25 s delays output; 9999 suppresses it
// - main level writable while running whatever write permission says
// - second function restricts frequency range where stall prevention acts
// - settings writable only while user group read select is 0; the control register stays writable at any group
// - indication holds longer than 100 ms, then off when current at level
// - when both levels apply, the smaller one wins
// - during acceleration the frequency-selected second level is not used; with follow select on, the second level still applies while accelerating
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module spcl_stall_ctrl #(
   parameter int STEP_CYCLES = spcl_pkg::STEP_CYCLES,
   parameter int MIN_ON_CYCLES = spcl_pkg::MIN_ON_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] current_inverter,
   input wire logic [15:0] current_pm,
   input wire logic [15:0] output_freq,
   input wire spcl_pkg::spcl_motion_type motion,
   input wire logic running,
   input wire logic second_set_select,
   input wire logic [9:0] analog_level_input,
   output spcl_pkg::spcl_freq_cmd_type freq_cmd,
   output logic voltage_reduce,
   output logic output_shutoff,
   output logic stall_indication_output
);
   spcl_pkg::spcl_settings_type cfg;
   spcl_pkg::spcl_ind_type ind_state;
   spcl_pkg::spcl_ind_type next_ind_state;
   logic [31:0] tick_cnt;
   logic [31:0] on_cnt;
   logic [15:0] delay_steps;
   logic stall_active;
   logic second_in_use;
   logic [15:0] active_level_q;

   // apb decode
   wire setup = psel && !penable;
   wire access = psel && penable && pready;
   wire hit_level = paddr == spcl_pkg::ADDR_LEVEL;
   wire hit_factor = paddr == spcl_pkg::ADDR_FACTOR;
   wire hit_second_level = paddr == spcl_pkg::ADDR_SECOND_LEVEL;
   wire hit_second_freq = paddr == spcl_pkg::ADDR_SECOND_FREQ;
   wire hit_start = paddr == spcl_pkg::ADDR_START_FREQ;
   wire hit_analog = paddr == spcl_pkg::ADDR_ANALOG;
   wire hit_control = paddr == spcl_pkg::ADDR_CONTROL;
   wire hit_delay = paddr == spcl_pkg::ADDR_DELAY;
   wire hit_status = paddr == spcl_pkg::ADDR_STATUS;
   wire mapped = hit_level || hit_factor || hit_second_level || hit_second_freq || hit_start
      || hit_analog || hit_control || hit_delay || hit_status;
   wire [15:0] wlo = pwdata[15:0];
   wire [15:0] whi = pwdata[31:16];
   wire [7:0] w_opsel = pwdata[spcl_pkg::CTRL_OPSEL_LSB +: 8];

   // range checks on written values
   wire level_ok = wlo <= spcl_pkg::PCT_MAX || wlo == spcl_pkg::SENTINEL;
   wire factor_ok = wlo <= spcl_pkg::FACTOR_MAX || wlo == spcl_pkg::SENTINEL;
   wire second_level_ok = wlo <= spcl_pkg::PCT_MAX;
   wire second_freq_ok = pwdata[spcl_pkg::FREQ_FOLLOW_BIT] || wlo <= spcl_pkg::FREQ_MAX;
   wire start_ok = wlo <= spcl_pkg::FREQ_MAX;
   wire analog_ok = wlo <= spcl_pkg::PCT_MAX && whi <= spcl_pkg::PCT_MAX;
   wire opsel_ok = w_opsel <= spcl_pkg::OPSEL_TABLE_MAX || w_opsel == spcl_pkg::OPSEL_ALL_ON
      || w_opsel == spcl_pkg::OPSEL_NO_FAST;
   wire delay_ok = wlo <= spcl_pkg::DELAY_MAX || wlo == spcl_pkg::SENTINEL;
   wire value_ok = (hit_level && level_ok) || (hit_factor && factor_ok)
      || (hit_second_level && second_level_ok) || (hit_second_freq && second_freq_ok)
      || (hit_start && start_ok) || (hit_analog && analog_ok) || (hit_control && opsel_ok)
      || (hit_delay && delay_ok);

   // permission: the group selector itself stays writable so software can open the set again
   wire group_open = cfg.user_group == 8'h00;
   wire run_locked = running && cfg.write_perm == 2'b00;
   wire perm_ok = hit_control || (group_open && (hit_level || !run_locked));
   wire write_ok = value_ok && perm_ok;
   wire next_err = !mapped || (pwrite && (hit_status || !write_ok));
   wire do_write = access && pwrite && !pslverr;

   // current reference selection
   wire [15:0] current = cfg.pm_motor ? current_pm : current_inverter;

   // analog variable level, signed interpolation zero + (full - zero) * input / 1024
   wire signed [16:0] analog_span = $signed({1'b0, cfg.analog_full}) - $signed({1'b0, cfg.analog_zero});
   wire signed [27:0] analog_prod = analog_span * $signed({1'b0, analog_level_input});
   wire signed [17:0] analog_step = 18'(analog_prod >>> spcl_pkg::ANALOG_BITS);
   wire signed [17:0] analog_sum = $signed({2'b00, cfg.analog_zero}) + analog_step;
   wire [15:0] analog_level = analog_sum[15:0];
   wire analog_mode = cfg.level == spcl_pkg::SENTINEL;
   wire [15:0] base_level = analog_mode ? analog_level : cfg.level;

   // high frequency reduction, never raises the level
   wire reduce_on = cfg.factor != spcl_pkg::SENTINEL && output_freq > cfg.start_freq;
   wire [31:0] reduced_prod = 32'(base_level) * 32'(cfg.factor);
   wire [15:0] reduced = 16'(reduced_prod / spcl_pkg::FACTOR_UNIT);
   wire [15:0] main_level = (reduce_on && reduced < base_level) ? reduced : base_level;

   // second level selection
   wire second_valid = cfg.second_level != 16'h0000;
   wire by_select = cfg.follow_select && second_set_select;
   wire by_freq = !cfg.follow_select && cfg.second_freq != 16'h0000 && output_freq <= cfg.second_freq
      && motion != spcl_pkg::SPCL_ACCEL;
   wire use_second = second_valid && (by_select || by_freq);
   wire [15:0] active_level = (use_second && cfg.second_level < main_level)
      ? cfg.second_level : main_level;

   // operation select gating; 100 and 101 ignore the per-condition bits
   wire table_mode = cfg.opsel <= spcl_pkg::OPSEL_TABLE_MAX;
   wire fast_enabled = !cfg.opsel[spcl_pkg::OPSEL_FAST_OFF_BIT];
   wire cond_off = table_mode && (
      (motion == spcl_pkg::SPCL_ACCEL && cfg.opsel[spcl_pkg::OPSEL_ACC_OFF_BIT])
      || (motion == spcl_pkg::SPCL_CONST && cfg.opsel[spcl_pkg::OPSEL_CONST_OFF_BIT])
      || (motion == spcl_pkg::SPCL_DECEL && cfg.opsel[spcl_pkg::OPSEL_DEC_OFF_BIT]));
   wire ind_allowed = !(table_mode && cfg.opsel[spcl_pkg::OPSEL_IND_OFF_BIT]);
   wire stall_enabled = cfg.level != 16'h0000 && !cond_off;
   wire next_stall = stall_enabled && running && current > active_level;
   wire next_shutoff = fast_enabled && running && current > spcl_pkg::FAST_LIMIT_DEF;

   // frequency correction for the current motion state
   spcl_pkg::spcl_freq_cmd_type next_cmd;
   assign next_cmd.decelerate = next_stall && motion != spcl_pkg::SPCL_DECEL;
   assign next_cmd.hold = next_stall && motion == spcl_pkg::SPCL_DECEL;

   // indication timing
   wire ind_never = cfg.delay == spcl_pkg::SENTINEL || !ind_allowed;
   wire tick = tick_cnt == 32'(STEP_CYCLES - 1);
   wire delay_done = delay_steps >= cfg.delay;
   wire min_on_done = on_cnt >= 32'(MIN_ON_CYCLES);

   always_comb begin
      next_ind_state = ind_state;
      unique case (ind_state)
         spcl_pkg::IND_IDLE: begin
            if (stall_active && !ind_never) begin
               next_ind_state = spcl_pkg::IND_WAIT;
            end
         end
         spcl_pkg::IND_WAIT: begin
            if (!stall_active || ind_never) begin
               next_ind_state = spcl_pkg::IND_IDLE;
            end else if (delay_done) begin
               next_ind_state = spcl_pkg::IND_ON;
            end
         end
         spcl_pkg::IND_ON: begin
            if (ind_never || (min_on_done && !stall_active)) begin
               next_ind_state = spcl_pkg::IND_IDLE;
            end
         end
         default: begin
            next_ind_state = spcl_pkg::IND_IDLE;
         end
      endcase
   end

   // apb read mux
   wire [31:0] status_word = {active_level_q, 12'h000, second_in_use, output_shutoff,
      stall_indication_output, stall_active};
   wire [31:0] control_word = {6'h00, cfg.write_perm, cfg.user_group, cfg.opsel, 6'h00, cfg.pm_motor,
      cfg.voltage_reduction};
   wire [31:0] next_rdata =
      hit_level ? {16'h0000, cfg.level} :
      hit_factor ? {16'h0000, cfg.factor} :
      hit_second_level ? {16'h0000, cfg.second_level} :
      hit_second_freq ? {cfg.follow_select, 15'h0000, cfg.second_freq} :
      hit_start ? {16'h0000, cfg.start_freq} :
      hit_analog ? {cfg.analog_full, cfg.analog_zero} :
      hit_control ? control_word :
      hit_delay ? {16'h0000, cfg.delay} :
      hit_status ? status_word : 32'h0000_0000;

   // bus answer: one access cycle, data and error prepared in setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup && next_err;
         prdata <= (setup && !pwrite) ? next_rdata : 32'h0000_0000;
      end
   end

   // settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= '{level: spcl_pkg::LEVEL_DEF, factor: spcl_pkg::SENTINEL,
            second_level: spcl_pkg::SECOND_LEVEL_DEF, follow_select: 1'b0, second_freq: 16'h0000,
            start_freq: spcl_pkg::START_FREQ_DEF, analog_zero: spcl_pkg::ANALOG_ZERO_DEF,
            analog_full: spcl_pkg::ANALOG_FULL_DEF, voltage_reduction: 1'b1, pm_motor: 1'b0,
            opsel: 8'h00, user_group: 8'h00, write_perm: 2'b00, delay: 16'h0000};
      end else if (do_write) begin
         if (hit_level) begin
            cfg.level <= wlo;
         end
         if (hit_factor) begin
            cfg.factor <= wlo;
         end
         if (hit_second_level) begin
            cfg.second_level <= wlo;
         end
         if (hit_second_freq) begin
            cfg.second_freq <= wlo;
            cfg.follow_select <= pwdata[spcl_pkg::FREQ_FOLLOW_BIT];
         end
         if (hit_start) begin
            cfg.start_freq <= wlo;
         end
         if (hit_analog) begin
            cfg.analog_zero <= wlo;
            cfg.analog_full <= whi;
         end
         if (hit_control) begin
            cfg.voltage_reduction <= pwdata[spcl_pkg::CTRL_VRED_BIT];
            cfg.pm_motor <= pwdata[spcl_pkg::CTRL_PM_BIT];
            cfg.opsel <= w_opsel;
            cfg.user_group <= pwdata[spcl_pkg::CTRL_UGRP_LSB +: 8];
            cfg.write_perm <= pwdata[spcl_pkg::CTRL_WPERM_LSB +: 2];
         end
         if (hit_delay) begin
            cfg.delay <= wlo;
         end
      end
   end

   // control path, registered every cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_active <= 1'b0;
         second_in_use <= 1'b0;
         active_level_q <= 16'h0000;
         freq_cmd <= '0;
         voltage_reduce <= 1'b0;
         output_shutoff <= 1'b0;
      end else begin
         stall_active <= next_stall;
         second_in_use <= use_second;
         active_level_q <= active_level;
         freq_cmd <= next_cmd;
         voltage_reduce <= next_stall && !cfg.voltage_reduction;
         output_shutoff <= next_shutoff;
      end
   end

   // indication state and timers; tick counter free-runs only while waiting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ind_state <= spcl_pkg::IND_IDLE;
         tick_cnt <= 32'h0000_0000;
         delay_steps <= 16'h0000;
         on_cnt <= 32'h0000_0000;
         stall_indication_output <= 1'b0;
      end else begin
         ind_state <= next_ind_state;
         stall_indication_output <= next_ind_state == spcl_pkg::IND_ON;
         if (ind_state != spcl_pkg::IND_WAIT || tick) begin
            tick_cnt <= 32'h0000_0000;
         end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
         end
         if (ind_state != spcl_pkg::IND_WAIT) begin
            delay_steps <= 16'h0000;
         end else if (tick && !delay_done) begin
            delay_steps <= delay_steps + 16'h0001;
         end
         // saturates so a long stall cannot wrap it back below the least on time
         if (ind_state != spcl_pkg::IND_ON) begin
            on_cnt <= 32'h0000_0000;
         end else if (!min_on_done) begin
            on_cnt <= on_cnt + 32'h0000_0001;
         end
      end
   end
endmodule : spcl_stall_ctrl
